// File: core/gar_alt_route.sv
// gar_alt_route: routes one group of alternate functions onto the multi-function pins.
// assumes gp and neighbouring pin logic hand in their own drive; all inputs are synchronous.
//
// How it works
// - active-low wake function pin going low requests leaving off or hibernate
// - 32 kHz clock function pin is passed to the rtc as reference
// - data-available output is 1 when the aux converter holds requested data
// - adc frame clock function drives the adc frame clock on pin 5
// - inverted adc frame clock function drives its inverse on pin 6
// - adc bit clock function drives the adc bit clock on pin 8
// - no-power fault output follows undervoltage lockout with one cycle delay
// - charge indicator flashes at a rate set by charging status
// - audio output clock divides the system clock by 2 x (output clock divider setting + 1)
// - programming window output is high in the pre-active state
// - otherwise it acts as power-on output, optionally kept through off
// - flash-active output is high while either current sink flashes
// - mic bias current detect output is 1 while current is detected
// - mic bias short output is 1 while a short is detected
// - each mic detection rise also raises an interrupt pulse
// - wall path switch drives the external transistor on while wall is present
// - line-above-battery output turns the transistor on while line exceeds battery
// - led drains c, d, e are open drain, pulling low to light
// - select 0000 gives plain gp behaviour, other values alternate functions
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gar_alt_route #(
	parameter logic [gar_pkg::TOG_W-1:0] CHG_SLOW_HALF =
		gar_pkg::TOG_W'(gar_pkg::CHG_SLOW_HALF_NS / gar_pkg::CLK_PERIOD_NS),
	parameter logic [gar_pkg::TOG_W-1:0] CHG_FAST_HALF =
		gar_pkg::TOG_W'(gar_pkg::CHG_FAST_HALF_NS / gar_pkg::CLK_PERIOD_NS)
) (
	// clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_n,
	// register port
	input  wire logic [gar_pkg::AW-1:0]    i_addr,
	input  wire logic [gar_pkg::DW-1:0]    i_wdata,
	input  wire logic                      i_wr,
	input  wire logic                      i_rd,
	output logic      [gar_pkg::DW-1:0]    o_rdata,
	// pins
	input  wire logic [gar_pkg::NPIN-1:0]  i_pin_in,
	output logic      [gar_pkg::NPIN-1:0]  o_pin_out,
	output logic      [gar_pkg::NPIN-1:0]  o_pin_oe,
	// drive from gp logic and from neighbouring functions
	input  wire logic [gar_pkg::NPIN-1:0]  i_gp_out,
	input  wire logic [gar_pkg::NPIN-1:0]  i_gp_oe,
	input  wire logic [gar_pkg::NPIN-1:0]  i_nbr_out,
	input  wire logic [gar_pkg::NPIN-1:0]  i_nbr_oe,
	// internal sources
	input  wire logic                      i_aux_conv_data_avail,
	input  wire logic                      i_adc_lrclk,
	input  wire logic                      i_adc_bclk,
	input  wire logic                      i_undervoltage_lockout_n,
	input  wire logic [1:0]                i_chg_mode,
	input  wire gar_pkg::gar_pwr_t         i_pwr_state,
	input  wire logic                      i_current_sink_a_flashing,
	input  wire logic                      i_current_sink_b_flashing,
	input  wire logic                      i_mic_bias_current_det,
	input  wire logic                      i_mic_bias_short_det,
	input  wire logic                      i_wall_present,
	input  wire logic                      i_line_above_batt_switch,
	// internal sinks
	output logic                           o_wake_req,
	output logic                           o_rtc_ref_sel,
	output logic                           o_rtc_ref_clk,
	output logic                           o_lrclk_dac_only,
	output logic                           o_bclk_dac_only,
	output logic                           o_no_power_fault_n,
	output logic      [1:0]                o_mic_irq,
	output logic                           o_sink_flash_trigger_bit
);
	import gar_pkg::*;

	typedef struct packed {
		gar_fn_arr_t     fn;
		logic            dev_keep;
		logic [2:0]      led_on;
		logic [3:0]      output_clock_divider;
		logic            dev_prog;
		logic            flash_act;
		logic            aux_avail;
		logic            wake_req;
		logic            rtc_sel;
		logic            rtc_clk;
		logic            no_pwr_n;
		logic [1:0]      mic_prev;
		logic [1:0]      mic_irq;
		logic            sink_trig;
		logic            lr_dac_only;
		logic            bclk_dac_only;
		logic [NPIN-1:0] pin_out;
		logic [NPIN-1:0] pin_oe;
		logic [DW-1:0]   rdata;
	} gar_state_t;

	gar_state_t      st_reg;
	gar_state_t      st_next;
	gar_tog_if       tog_chg ();
	gar_tog_if       tog_aud ();
	logic            chg_led;
	logic [NPIN-1:0] sel_wake;
	logic [NPIN-1:0] sel_clk32;
	logic [NPIN-1:0] clk32_first;

	////////////////////////////////////////////////////////////////////////////////
	// mask of pins whose select field holds the given code
	function automatic logic [NPIN-1:0] any_sel(input gar_fn_arr_t f, input logic [FNW-1:0] c);
		logic [NPIN-1:0] m;
		m = '0;
		for (int p = 0; p < NPIN; p++) begin
			m[p] = (f[p] == c);
		end
		return m;
	endfunction : any_sel

	////////////////////////////////////////////////////////////////////////////////
	// flashers: one for the charge led, one for the audio output clock
	assign tog_chg.en   = (i_chg_mode == CHG_TRICKLE) || (i_chg_mode == CHG_FAST);
	assign tog_chg.half = (i_chg_mode == CHG_TRICKLE) ? CHG_SLOW_HALF : CHG_FAST_HALF;
	// divider only runs while some pin wants it, saving toggling power
	assign tog_aud.en   = |any_sel(st_reg.fn, FN_AUD_CLK);
	assign tog_aud.half = TOG_W'(st_reg.output_clock_divider) + TOG_W'(1);

	gar_tog_gen u_tog_chg (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.tog     (tog_chg)
	);

	gar_tog_gen u_tog_aud (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.tog     (tog_aud)
	);

	// done shows steady, charging flashes, idle stays dark
	always_comb begin
		case (i_chg_mode)
			CHG_DONE:              chg_led = 1'b1;
			CHG_TRICKLE, CHG_FAST: chg_led = tog_chg.out;
			default:               chg_led = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// input functions: lowest selected pin wins the rtc reference
	assign sel_wake    = any_sel(st_reg.fn, FN_WAKE);
	assign sel_clk32   = any_sel(st_reg.fn, FN_CLK32);
	assign clk32_first = sel_clk32 & NPIN'(~sel_clk32 + 1'b1);

	////////////////////////////////////////////////////////////////////////////////
	// next state: register port, flags and pin mux
	always_comb begin
		st_next = st_reg;

		// function select and control writes
		for (int p = 0; p < NPIN; p++) begin
			if (i_wr && (i_addr == ADDR_FN0 + AW'(p / 4))) begin
				st_next.fn[p] = i_wdata[(p % 4) * FNW +: FNW];
			end
		end
		st_next.sink_trig = 1'b0;
		if (i_wr && (i_addr == ADDR_CTRL)) begin
			st_next.dev_keep  = i_wdata[CTRL_DEV_KEEP];
			st_next.sink_trig = i_wdata[CTRL_FLASH_TRG];
			st_next.led_on    = i_wdata[CTRL_LED_LSB +: 3];
			st_next.output_clock_divider = i_wdata[CTRL_DIV_LSB +: 4];
		end

		// status flags
		st_next.wake_req  = |(sel_wake & ~i_pin_in);
		st_next.rtc_sel   = |sel_clk32;
		st_next.rtc_clk   = |(clk32_first & i_pin_in);
		st_next.aux_avail = i_aux_conv_data_avail;
		st_next.no_pwr_n  = i_undervoltage_lockout_n;
		st_next.flash_act = i_current_sink_a_flashing | i_current_sink_b_flashing;
		st_next.mic_prev  = {i_mic_bias_short_det, i_mic_bias_current_det};
		// rising edge only, so a held detection does not flood the controller
		st_next.mic_irq   = st_next.mic_prev & ~st_reg.mic_prev;
		st_next.lr_dac_only   = (st_reg.fn[PIN_ADC_LR] == FN_ADC_CLK) ||
		                        (st_reg.fn[PIN_ADC_LR_INV] == FN_ADC_CLK);
		st_next.bclk_dac_only = (st_reg.fn[PIN_ADC_BCLK] == FN_ADC_CLK);

		// programming window tracks power-on, may survive off on request
		case (i_pwr_state)
			PS_PREACTIVE, PS_ACTIVE: st_next.dev_prog = 1'b1;
			PS_OFF:                  st_next.dev_prog = st_reg.dev_keep & st_reg.dev_prog;
			default:                 st_next.dev_prog = st_reg.dev_prog;
		endcase

		// pin mux: each source reaches a pin only through its own code
		for (int p = 0; p < NPIN; p++) begin
			st_next.pin_out[p] = 1'b0;
			st_next.pin_oe[p]  = 1'b1;
			case (st_reg.fn[p])
				FN_GPIO: begin
					st_next.pin_out[p] = i_gp_out[p];
					st_next.pin_oe[p]  = i_gp_oe[p];
				end
				FN_WAKE, FN_CLK32: begin
					st_next.pin_oe[p]  = 1'b0;
				end
				FN_AUX_AVAIL: st_next.pin_out[p] = i_aux_conv_data_avail;
				FN_ADC_CLK: begin
					// on any other pin this code has no source, so the pin floats
					if (p == PIN_ADC_LR) begin
						st_next.pin_out[p] = i_adc_lrclk;
					end else if (p == PIN_ADC_LR_INV) begin
						st_next.pin_out[p] = ~i_adc_lrclk;
					end else if (p == PIN_ADC_BCLK) begin
						st_next.pin_out[p] = i_adc_bclk;
					end else begin
						st_next.pin_oe[p]  = 1'b0;
					end
				end
				FN_NO_PWR:    st_next.pin_out[p] = i_undervoltage_lockout_n;
				FN_CHG_IND:   st_next.pin_out[p] = chg_led;
				FN_AUD_CLK:   st_next.pin_out[p] = tog_aud.out;
				FN_DEV_PROG:  st_next.pin_out[p] = st_reg.dev_prog;
				FN_FLASH_ACT: st_next.pin_out[p] = st_next.flash_act;
				FN_LED_DRAIN: begin
					st_next.pin_oe[p]  = st_reg.led_on[p % 3];
				end
				FN_WALL_SW:   st_next.pin_out[p] = ~i_wall_present;
				FN_LINE_GT:   st_next.pin_out[p] = ~i_line_above_batt_switch;
				FN_MIC_DET:   st_next.pin_out[p] = i_mic_bias_current_det;
				FN_MIC_SHT:   st_next.pin_out[p] = i_mic_bias_short_det;
				default: begin
					st_next.pin_out[p] = i_nbr_out[p];
					st_next.pin_oe[p]  = i_nbr_oe[p];
				end
			endcase
		end

		// read data stand only in the cycle after the strobe
		st_next.rdata = '0;
		if (i_rd) begin
			if (i_addr <= ADDR_FN3) begin
				for (int p = 0; p < NPIN; p++) begin
					if (AW'(p / 4) == i_addr) begin
						st_next.rdata[(p % 4) * FNW +: FNW] = st_reg.fn[p];
					end
				end
			end else if (i_addr == ADDR_CTRL) begin
				st_next.rdata[CTRL_DEV_KEEP]       = st_reg.dev_keep;
				st_next.rdata[CTRL_LED_LSB +: 3]   = st_reg.led_on;
				st_next.rdata[CTRL_DIV_LSB +: 4]   = st_reg.output_clock_divider;
			end else if (i_addr == ADDR_STAT) begin
				st_next.rdata[STAT_AUX]      = st_reg.aux_avail;
				st_next.rdata[STAT_MIC_DET]  = st_reg.mic_prev[0];
				st_next.rdata[STAT_MIC_SHT]  = st_reg.mic_prev[1];
				st_next.rdata[STAT_WAKE]     = st_reg.wake_req;
				st_next.rdata[STAT_FLASH]    = st_reg.flash_act;
				st_next.rdata[STAT_DEV_PROG] = st_reg.dev_prog;
				st_next.rdata[STAT_NO_PWR_N] = st_reg.no_pwr_n;
				st_next.rdata[STAT_RTC_SEL]  = st_reg.rtc_sel;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register; all-zero reset selects gp on every pin and leaves every pin undriven until the first clock after release
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, each straight from the state register
	assign o_rdata                  = st_reg.rdata;
	assign o_pin_out                = st_reg.pin_out;
	assign o_pin_oe                 = st_reg.pin_oe;
	assign o_wake_req               = st_reg.wake_req;
	assign o_rtc_ref_sel            = st_reg.rtc_sel;
	assign o_rtc_ref_clk            = st_reg.rtc_clk;
	assign o_lrclk_dac_only         = st_reg.lr_dac_only;
	assign o_bclk_dac_only          = st_reg.bclk_dac_only;
	assign o_no_power_fault_n       = st_reg.no_pwr_n;
	assign o_mic_irq                = st_reg.mic_irq;
	assign o_sink_flash_trigger_bit = st_reg.sink_trig;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb_main @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_wake_request: assert property (
		(|(sel_wake & ~i_pin_in)) |=> o_wake_req) else $error("wake pin low but no request");
	a_fault_follow: assert property (
		1'b1 |=> o_no_power_fault_n == $past(i_undervoltage_lockout_n))
		else $error("fault output does not follow lockout");
	a_adc_lr_pin: assert property (
		st_reg.fn[PIN_ADC_LR] == FN_ADC_CLK |=>
		o_pin_oe[PIN_ADC_LR] && o_pin_out[PIN_ADC_LR] == $past(i_adc_lrclk))
		else $error("pin 5 not carrying adc frame clock");
	a_adc_inv_pin: assert property (
		st_reg.fn[PIN_ADC_LR_INV] == FN_ADC_CLK |=>
		o_pin_oe[PIN_ADC_LR_INV] && o_pin_out[PIN_ADC_LR_INV] != $past(i_adc_lrclk))
		else $error("pin 6 not carrying inverted frame clock");
	a_adc_bclk_pin: assert property (
		st_reg.fn[PIN_ADC_BCLK] == FN_ADC_CLK |=>
		o_pin_oe[PIN_ADC_BCLK] && o_pin_out[PIN_ADC_BCLK] == $past(i_adc_bclk))
		else $error("pin 8 not carrying adc bit clock");
	a_dev_prog_pre: assert property (
		i_pwr_state == PS_PREACTIVE |=> st_reg.dev_prog) else $error("window low in pre-active");
	a_dev_prog_off: assert property (
		i_pwr_state == PS_OFF && !st_reg.dev_keep |=> !st_reg.dev_prog)
		else $error("window not cleared in off");
	a_flash_active: assert property (
		1'b1 |=> st_reg.flash_act ==
		($past(i_current_sink_a_flashing) || $past(i_current_sink_b_flashing)))
		else $error("flash-active does not match sinks");
	// the pulse is registered beside the detect sample: one cycle late, one cycle long
	a_mic_irq_edge: assert property (
		$rose(i_mic_bias_current_det) |=> o_mic_irq[0] ##1 !o_mic_irq[0])
		else $error("mic detect rise without interrupt");

	for (genvar gi = 0; gi < NPIN; gi++) begin : g_pin_chk
		a_gp_passthru: assert property (
			st_reg.fn[gi] == FN_GPIO |=>
			o_pin_out[gi] == $past(i_gp_out[gi]) && o_pin_oe[gi] == $past(i_gp_oe[gi]))
			else $error("gp drive not passed through");
		a_aux_avail: assert property (
			st_reg.fn[gi] == FN_AUX_AVAIL |=> o_pin_out[gi] == $past(i_aux_conv_data_avail))
			else $error("data-available pin wrong");
		a_mic_det_pin: assert property (
			st_reg.fn[gi] == FN_MIC_DET |=> o_pin_out[gi] == $past(i_mic_bias_current_det))
			else $error("mic detect pin wrong");
		a_mic_sht_pin: assert property (
			st_reg.fn[gi] == FN_MIC_SHT |=> o_pin_out[gi] == $past(i_mic_bias_short_det))
			else $error("mic short pin wrong");
		a_led_open_drain: assert property (
			st_reg.fn[gi] == FN_LED_DRAIN |=> !o_pin_out[gi])
			else $error("led drain driven high");
		a_other_source: assert property (
			st_reg.fn[gi] == 4'hF |=> o_pin_out[gi] == $past(i_nbr_out[gi]))
			else $error("foreign function not passed through");
	end

	c_adc_lr_used: cover property (st_reg.fn[PIN_ADC_LR] == FN_ADC_CLK ##1 o_lrclk_dac_only);
	c_dev_prog_on: cover property ($rose(st_reg.dev_prog));
	c_mic_irq: cover property (o_mic_irq[1]);
	c_status_read: cover property (i_rd && i_addr == ADDR_STAT ##1 o_rdata != '0);

endmodule : gar_alt_route
`default_nettype wire

// File: core/gar_pkg.sv
// gar_pkg: constants, codes and types shared by the alternate-function pin router.
// assumes a single 125 MHz system clock and a plain address/strobe register port.
package gar_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int NPIN = 13;             // multi-function pins handled by the router
	localparam int AW   = 8;              // register address width
	localparam int DW   = 16;             // register data width
	localparam int FNW  = 4;              // function select field width
	localparam int TOG_W = 27;            // toggle generator counter width

	typedef logic [NPIN-1:0][FNW-1:0] gar_fn_arr_t;

	////////////////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [AW-1:0] ADDR_FN0  = 8'h00;  // pins 0..3, then 01h..03h for the rest
	localparam logic [AW-1:0] ADDR_FN3  = 8'h03;
	localparam logic [AW-1:0] ADDR_CTRL = 8'h04;
	localparam logic [AW-1:0] ADDR_STAT = 8'h05;
	localparam logic [FNW-1:0] FN_RST   = 4'h0;   // every pin starts as plain gp pin
	localparam logic [DW-1:0]  CTRL_RST = 16'h0000;

	// control fields
	localparam int CTRL_DEV_KEEP  = 0;    // keep the programming window through OFF
	localparam int CTRL_FLASH_TRG = 1;    // write 1: one-cycle software flash trigger
	localparam int CTRL_LED_LSB   = 2;    // three led drain enables c, d, e
	localparam int CTRL_DIV_LSB   = 8;    // four-bit output clock divider

	// status fields
	localparam int STAT_AUX      = 0;
	localparam int STAT_MIC_DET  = 1;
	localparam int STAT_MIC_SHT  = 2;
	localparam int STAT_WAKE     = 3;
	localparam int STAT_FLASH    = 4;
	localparam int STAT_DEV_PROG = 5;
	localparam int STAT_NO_PWR_N = 6;
	localparam int STAT_RTC_SEL  = 7;

	////////////////////////////////////////////////////////////////////////////////
	// function select codes
	localparam logic [FNW-1:0] FN_GPIO      = 4'h0;
	localparam logic [FNW-1:0] FN_WAKE      = 4'h1;
	localparam logic [FNW-1:0] FN_CLK32     = 4'h2;
	localparam logic [FNW-1:0] FN_AUX_AVAIL = 4'h3;
	localparam logic [FNW-1:0] FN_ADC_CLK   = 4'h4;   // meaning depends on pin 5, 6 or 8
	localparam logic [FNW-1:0] FN_NO_PWR    = 4'h5;
	localparam logic [FNW-1:0] FN_CHG_IND   = 4'h6;
	localparam logic [FNW-1:0] FN_AUD_CLK   = 4'h7;
	localparam logic [FNW-1:0] FN_DEV_PROG  = 4'h8;
	localparam logic [FNW-1:0] FN_FLASH_ACT = 4'h9;
	localparam logic [FNW-1:0] FN_LED_DRAIN = 4'hA;   // pin index mod 3 picks drain c, d, e
	localparam logic [FNW-1:0] FN_WALL_SW   = 4'hB;
	localparam logic [FNW-1:0] FN_LINE_GT   = 4'hC;
	localparam logic [FNW-1:0] FN_MIC_DET   = 4'hD;
	localparam logic [FNW-1:0] FN_MIC_SHT   = 4'hE;

	localparam int PIN_ADC_LR     = 5;
	localparam int PIN_ADC_LR_INV = 6;
	localparam int PIN_ADC_BCLK   = 8;

	////////////////////////////////////////////////////////////////////////////////
	// charge status codes and indicator timing
	localparam logic [1:0] CHG_NONE    = 2'h0;
	localparam logic [1:0] CHG_TRICKLE = 2'h1;
	localparam logic [1:0] CHG_FAST    = 2'h2;
	localparam logic [1:0] CHG_DONE    = 2'h3;

	localparam int unsigned CLK_PERIOD_NS    = 8;
	localparam int unsigned CHG_SLOW_HALF_NS = 500_000_000;
	localparam int unsigned CHG_FAST_HALF_NS = 125_000_000;

	typedef enum logic [1:0] {PS_OFF, PS_HIBERNATE, PS_PREACTIVE, PS_ACTIVE} gar_pwr_t;

endpackage : gar_pkg

// File: core/gar_tog_gen.sv
// gar_tog_gen: square wave whose level flips every "half" clock cycles.
// assumes en and half are steady for many cycles; a change of half restarts nothing, dropping en clears count and output.
`timescale 1ns/1ps
`default_nettype none
module gar_tog_gen (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// request and output
	gar_tog_if.gen   tog
);
	import gar_pkg::*;

	typedef struct packed {
		logic [TOG_W-1:0] cnt;
		logic             out;
	} gar_tog_st_t;

	gar_tog_st_t st_reg;
	gar_tog_st_t st_next;

	////////////////////////////////////////////////////////////////////////////////
	// half of 0 or 1 toggles every cycle, so the output never stalls
	always_comb begin
		st_next = st_reg;
		if (!tog.en) begin
			st_next = '0;
		end else if (TOG_W'(st_reg.cnt + 1'b1) >= tog.half) begin
			st_next.cnt = '0;
			st_next.out = ~st_reg.out;
		end else begin
			st_next.cnt = TOG_W'(st_reg.cnt + 1'b1);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tog.out = st_reg.out;

	////////////////////////////////////////////////////////////////////////////////
	a_tog_idle_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!tog.en |=> !tog.out) else $error("toggle output high while disabled");
	c_tog_flip: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		tog.en && $rose(tog.out));

endmodule : gar_tog_gen
`default_nettype wire

// File: core/gar_tog_if.sv
// gar_tog_if: request and output of one toggle generator.
// assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface gar_tog_if;
	logic                      en;
	logic [gar_pkg::TOG_W-1:0] half;
	logic                      out;
	modport gen  (input en, input half, output out);
	modport user (output en, output half, input out);
endinterface : gar_tog_if
`default_nettype wire

// File: test/gar_alt_route_tb_top.sv
// gar_alt_route_tb_top: function table per pin, then wake, clocks and pulses.
// assumes the far side model drives every pin the router leaves undriven.
`timescale 1ns/1ps
`default_nettype none
module gar_alt_route_tb_top;
	import gar_pkg::*;
	typedef struct {int p; logic [3:0] c; logic [15:0] k; logic [11:0] s; logic o, e;} gar_row_t;
	logic        i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, wake_n = 1'b1, run = 1'b0;
	logic [7:0]  i_addr  = 8'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic [11:0] src     = 12'h008;
	logic [1:0]  chg     = 2'h0;
	logic [12:0] far, lvl, p_out, p_oe;
	logic [15:0] rdata;
	logic [1:0]  irq;
	logic        ref_sel, ref_clk, trig, wreq, lr_do, bc_do, nf;
	logic [16:0] mon;
	int          n_fail = 0, compares = 0;
	// wire level from the router's enable; far side drives the rest
	assign lvl = (p_oe & p_out) | (~p_oe & far);
	assign mon = {trig, irq, ref_clk, lvl};
	gar_alt_route #(.CHG_SLOW_HALF(TOG_W'(4)), .CHG_FAST_HALF(TOG_W'(2))) u_dut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(rdata), .i_pin_in(lvl), .o_pin_out(p_out), .o_pin_oe(p_oe),
		.i_gp_out(13'h0AAA), .i_gp_oe(13'h1FFF), .i_nbr_out(13'h1555), .i_nbr_oe(13'h1FFF),
		.i_aux_conv_data_avail(src[0]), .i_adc_lrclk(src[1]), .i_adc_bclk(src[2]),
		.i_undervoltage_lockout_n(src[3]), .i_chg_mode(chg),
		.i_pwr_state(gar_pwr_t'(src[11:10])), .i_current_sink_a_flashing(src[4]),
		.i_current_sink_b_flashing(src[5]), .i_mic_bias_current_det(src[6]),
		.i_mic_bias_short_det(src[7]), .i_wall_present(src[8]), .i_line_above_batt_switch(src[9]),
		.o_wake_req(wreq), .o_rtc_ref_sel(ref_sel), .o_rtc_ref_clk(ref_clk),
		.o_lrclk_dac_only(lr_do), .o_bclk_dac_only(bc_do), .o_no_power_fault_n(nf),
		.o_mic_irq(irq), .o_sink_flash_trigger_bit(trig));
	gar_far_side u_far (.i_clk(i_clk), .i_wake_n(wake_n), .i_clk_run(run), .o_pin(far));
	// pin, code, control, sources {pwr, line, wall, sht, det, sink b, a, undervoltage_lockout_n_n, bclk, lr, aux}
	gar_row_t rows [20] = '{
		'{3, 4'h0, 16'h0000, 12'h008, 1'b1, 1'b1},
		'{2, 4'h3, 16'h0000, 12'h009, 1'b1, 1'b1},
		'{2, 4'h3, 16'h0000, 12'h008, 1'b0, 1'b1},
		'{5, 4'h4, 16'h0000, 12'h00A, 1'b1, 1'b1},
		'{6, 4'h4, 16'h0000, 12'h00A, 1'b0, 1'b1},
		'{8, 4'h4, 16'h0000, 12'h00C, 1'b1, 1'b1},
		'{2, 4'h4, 16'h0000, 12'h00E, 1'b0, 1'b0},
		'{4, 4'h5, 16'h0000, 12'h000, 1'b0, 1'b1},
		'{4, 4'h5, 16'h0000, 12'h008, 1'b1, 1'b1},
		'{7, 4'h9, 16'h0000, 12'h018, 1'b1, 1'b1},
		'{9, 4'h9, 16'h0000, 12'h028, 1'b1, 1'b1},
		'{10, 4'h8, 16'h0000, 12'h808, 1'b1, 1'b1},
		'{10, 4'h8, 16'h0000, 12'h008, 1'b0, 1'b1},
		'{11, 4'hD, 16'h0000, 12'h048, 1'b1, 1'b1},
		'{12, 4'hE, 16'h0000, 12'h088, 1'b1, 1'b1},
		'{1, 4'hB, 16'h0000, 12'h108, 1'b0, 1'b1},
		'{1, 4'hC, 16'h0000, 12'h208, 1'b0, 1'b1},
		'{0, 4'hA, 16'h001C, 12'h008, 1'b0, 1'b1},
		'{1, 4'hA, 16'h0000, 12'h008, 1'b0, 1'b0},
		'{3, 4'hF, 16'h0000, 12'h008, 1'b0, 1'b1}};
	// 125 MHz system clock
	initial forever #4 i_clk = ~i_clk;
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] x);
		@(posedge i_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		chk(rdata === x, "read data");
	endtask : rd
	// one pin selected, all others back to gp, then the pipeline settles
	task automatic sel(input int p, input logic [3:0] c, input logic [15:0] k);
		for (int a = 0; a < 4; a++) begin
			wr(8'(a), (a == p / 4) ? 16'(c) << (4 * (p % 4)) : 16'h0000);
		end
		wr(ADDR_CTRL, k);
		repeat (3) @(negedge i_clk);
	endtask : sel
	// hi counts high samples, otherwise level changes over 32 cycles
	task automatic cnt(input int i, input int x, input logic hi);
		int   c;
		logic pv;
		if (!hi) repeat (8) @(negedge i_clk);
		@(negedge i_clk);
		pv = mon[i];
		c  = (hi && pv === 1'b1) ? 1 : 0;
		repeat (32) begin
			@(negedge i_clk);
			c += hi ? int'(mon[i] === 1'b1) : int'(mon[i] !== pv);
			pv = mon[i];
		end
		chk(c == x, "activity count");
	endtask : cnt
	task automatic end_of_test;
		if (n_fail == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	// main sequence
	initial begin
		repeat (10) @(posedge i_clk);
		@(negedge i_clk);
		chk(p_oe === 13'h0000 && nf === 1'b0, "outputs in reset");
		// released away from the rising edge, so no check starts on a half-reset cycle
		i_rst_n <= 1'b1;
		repeat (2) @(negedge i_clk);
		chk(p_oe === 13'h1FFF, "gp drive after reset");
		rd(ADDR_CTRL, CTRL_RST);
		rd(ADDR_FN0, 16'h0000);
		rd(8'h3F, 16'h0000);
		foreach (rows[j]) begin
			src <= rows[j].s;
			sel(rows[j].p, rows[j].c, rows[j].k);
			chk(p_oe[rows[j].p] === rows[j].e, "pin enable");
			if (rows[j].e === 1'b1) chk(p_out[rows[j].p] === rows[j].o, "pin level");
			chk(lr_do === (rows[j].c == 4'h4 && rows[j].p inside {5, 6}), "frame split");
			chk(bc_do === (rows[j].c == 4'h4 && rows[j].p == 8), "bit clock split");
			chk(nf === rows[j].s[3], "fault output");
			rd(8'(rows[j].p / 4), 16'(rows[j].c) << (4 * (rows[j].p % 4)));
		end
		// keep option: the window survives a drop to off
		src <= 12'h808;
		sel(10, FN_DEV_PROG, 16'h0001);
		src <= 12'h008;
		repeat (3) @(negedge i_clk);
		chk(p_out[10] === 1'b1, "window kept through off");
		sel(0, FN_WAKE, 16'h0000);
		chk(p_oe[0] === 1'b0, "wake pin driven");
		wake_n <= 1'b0;
		repeat (3) @(negedge i_clk);
		chk(wreq === 1'b1, "wake request");
		rd(ADDR_STAT, 16'h0048);
		wake_n <= 1'b1;
		repeat (3) @(negedge i_clk);
		chk(wreq === 1'b0, "wake release");
		run <= 1'b1;
		sel(1, FN_CLK32, 16'h0000);
		chk(ref_sel === 1'b1, "reference select");
		cnt(13, 8, 1'b0);
		run <= 1'b0;
		// fast before slow: a shorter half period must never be passed by the count
		chg <= CHG_FAST;
		sel(4, FN_CHG_IND, 16'h0000);
		cnt(4, 16, 1'b0);
		chg <= CHG_TRICKLE;
		cnt(4, 8, 1'b0);
		chg <= CHG_DONE;
		cnt(4, 33, 1'b1);
		sel(4, FN_AUD_CLK, 16'h0100);
		cnt(4, 16, 1'b0);
		sel(0, FN_GPIO, 16'h0000);
		src <= 12'h048;
		cnt(14, 1, 1'b1);
		src <= 12'h0C8;
		cnt(15, 1, 1'b1);
		wr(ADDR_CTRL, 16'h0002);
		cnt(16, 1, 1'b1);
		end_of_test();
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge i_clk);
		n_fail++;
		end_of_test();
	end
endmodule : gar_alt_route_tb_top
`default_nettype wire

// File: test/gar_far_side.sv
// gar_far_side: board side of the pins, a wake line and a slow reference clock.
// assumes the bench steers the wake level and whether the clock runs.
`timescale 1ns/1ps
`default_nettype none
module gar_far_side #(
	parameter int HALF = 4
) (
	// clock and steering
	input  wire logic        i_clk,
	input  wire logic        i_wake_n,
	input  wire logic        i_clk_run,
	// pin levels
	output logic      [12:0] o_pin
);
	logic [3:0]  cnt_reg = 4'h0;
	logic        ck_reg  = 1'b0;
	logic [10:0] pat_reg = 11'h555;
	// clock stands still between runs; unused pins flip so stale levels never pass
	always_ff @(posedge i_clk) begin
		pat_reg <= ~pat_reg;
		if (!i_clk_run) begin
			cnt_reg <= 4'h0;
		end else if (cnt_reg == 4'(HALF - 1)) begin
			cnt_reg <= 4'h0;
			ck_reg  <= ~ck_reg;
		end else begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end
	// wake is active low and idles high
	assign o_pin = {pat_reg, ck_reg, i_wake_n};
endmodule : gar_far_side
`default_nettype wire
